/* File: inc/mih_pkg.sv */
// shared constants and types for the interrupt handler
package mih_pkg;
    // ********************************************************************
    // source slots and vectors
    // ********************************************************************
    localparam int NSRC = 21;
    localparam int IDX_W = 5;
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam logic [15:0] VEC_STEP = 16'h0008;
    localparam int SRC_EXT0 = 0;
    localparam int SRC_T0 = 1;
    localparam int SRC_EXT1 = 2;
    localparam int SRC_T1 = 3;
    localparam int SRC_RSVD = 19;
    localparam logic [NSRC-1:0] HW_CLR_MASK = 21'h00000F;
    localparam logic [NSRC-1:0] RSVD_MASK = 21'h080000;
    localparam int CALL_CYCLES = 4;
    // ********************************************************************
    // register byte offsets
    // ********************************************************************
    localparam logic [11:0] OFF_BASIC_EN = 12'h000;
    localparam logic [11:0] OFF_EXT_EN_A = 12'h004;
    localparam logic [11:0] OFF_EXT_EN_B = 12'h008;
    localparam logic [11:0] OFF_BASIC_PRI = 12'h00C;
    localparam logic [11:0] OFF_EXT_PRI_A = 12'h010;
    localparam logic [11:0] OFF_EXT_PRI_B = 12'h014;
    localparam logic [11:0] OFF_TIMER_CTL = 12'h018;
    localparam logic [11:0] OFF_PENDING = 12'h01C;
    localparam logic [11:0] OFF_STATUS = 12'h020;
    // ********************************************************************
    // field positions and reset values
    // ********************************************************************
    localparam int GIE_BIT = 7;
    localparam int EXT0_EDGE_BIT = 0;
    localparam int EXT0_FLAG_BIT = 1;
    localparam int EXT1_EDGE_BIT = 2;
    localparam int EXT1_FLAG_BIT = 3;
    localparam int T0_FLAG_BIT = 5;
    localparam int T1_FLAG_BIT = 7;
    localparam logic [7:0] REG8_RST = 8'h00;
    localparam logic [NSRC-1:0] PEND_RST = 21'h000000;

    typedef enum logic [1:0] {ST_IDLE, ST_CALL} mih_state_e;
endpackage

/* File: inc/mih_arb_if.sv */
// request bundle between the handler and its priority arbiter
`timescale 1ns/1ps
interface mih_arb_if #(parameter int N = 21, parameter int IW = 5);
    logic [N-1:0] pend;
    logic [N-1:0] en;
    logic [N-1:0] hi;
    logic hi_busy;
    logic lo_busy;
    logic valid;
    logic win_hi;
    logic [IW-1:0] idx;
    modport arb (input pend, en, hi, hi_busy, lo_busy,
                 output valid, win_hi, idx);
    modport core (output pend, en, hi, hi_busy, lo_busy,
                  input valid, win_hi, idx);
endinterface

/* File: rtl/mih_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module mih_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset
    input wire logic din, // asynchronous pin
    output logic dout // filtered level
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
            s3_r <= RST_VAL;
            dout <= RST_VAL;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // only a level seen on two stages counts
            if (s2_r == s3_r) begin
                dout <= s3_r;
            end
        end
    end
endmodule // mih_sync

/* File: rtl/mih_arbiter.sv */
// two-level fixed-order priority arbiter
`timescale 1ns/1ps
module mih_arbiter #(
    parameter int N = 21,
    parameter int IW = 5
) (
    mih_arb_if.arb a // request bundle
);
    logic [N-1:0] elig_hi;
    logic [N-1:0] elig_lo;
    logic [IW:0] pick_hi;
    logic [IW:0] pick_lo;

    // lowest index wins; msb of result flags a hit
    function automatic logic [IW:0] first_set(input logic [N-1:0] v);
        logic [IW:0] r;
        r = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, IW'(i)};
            end
        end
        return r;
    endfunction

    // a high routine is never preempted; low only preempted by high
    assign elig_hi = a.pend & a.en & a.hi & {N{~a.hi_busy}};
    assign elig_lo = a.pend & a.en & ~a.hi
                     & {N{~a.hi_busy & ~a.lo_busy}};
    assign pick_hi = first_set(elig_hi);
    assign pick_lo = first_set(elig_lo);
    assign a.valid = pick_hi[IW] | pick_lo[IW];
    assign a.win_hi = pick_hi[IW];
    assign a.idx = pick_hi[IW] ? pick_hi[IW-1:0] : pick_lo[IW-1:0];
endmodule // mih_arbiter

/* File: rtl/mih_handler.sv */
// interrupt handler: flags, enables, arbitration and call sequencing
`timescale 1ns/1ps
module mih_handler #(
    parameter int NSRC = mih_pkg::NSRC,
    parameter int CALL_CYCLES = mih_pkg::CALL_CYCLES
) (
    input wire logic clk, // 20 MHz system clock
    input wire logic rst, // synchronous, active high
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic ext_irq_pin_0, // external input 0, active low
    input wire logic ext_irq_pin_1, // external input 1, active low
    input wire logic [NSRC-1:0] src_event, // peripheral event pulses
    input wire logic instr_boundary, // current instruction completes
    input wire logic ea_clear_exec, // enable-clearing instruction runs
    input wire logic next_single, // following instruction is 1 cycle
    input wire logic return_from_interrupt_done, // return_from_interrupt completed
    output logic irq_req, // request is pending toward the core
    output logic call_start, // long_call begins this cycle
    output logic call_active, // long_call in progress
    output logic [15:0] call_vector, // service_routine address
    output logic [1:0] in_service // {high, low} routine active
);
    // ********************************************************************
    // declarations
    // ********************************************************************
    logic [7:0] basic_irq_enable_reg;
    logic [7:0] ext_irq_enable_reg_a;
    logic [7:0] ext_irq_enable_reg_b;
    logic [7:0] basic_priority_reg;
    logic [7:0] ext_priority_reg_a;
    logic [7:0] ext_priority_reg_b;
    logic [7:0] timer_ctl_store_r;
    logic [NSRC-1:0] pend_r;
    logic [NSRC-1:0] pend_nxt;
    mih_pkg::mih_state_e state_r;
    logic [2:0] call_cnt_r;
    logic [4:0] cur_idx_r;
    logic cur_hi_r;
    logic skip_one_r;
    logic hi_busy_r;
    logic lo_busy_r;
    logic pin0_lvl;
    logic pin1_lvl;
    logic pin0_prev_r;
    logic pin1_prev_r;

    mih_arb_if #(.N(NSRC), .IW(5)) arb ();

    // ********************************************************************
    // external pin conditioning
    // ********************************************************************
    mih_sync #(.RST_VAL(1'b1)) u_sync0 (
        .clk(clk),
        .rst(rst),
        .din(ext_irq_pin_0),
        .dout(pin0_lvl)
    );

    mih_sync #(.RST_VAL(1'b1)) u_sync1 (
        .clk(clk),
        .rst(rst),
        .din(ext_irq_pin_1),
        .dout(pin1_lvl)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            pin0_prev_r <= 1'b1;
            pin1_prev_r <= 1'b1;
        end else begin
            pin0_prev_r <= pin0_lvl;
            pin1_prev_r <= pin1_lvl;
        end
    end

    wire ext0_edge_select = timer_ctl_store_r[mih_pkg::EXT0_EDGE_BIT];
    wire ext1_edge_select = timer_ctl_store_r[mih_pkg::EXT1_EDGE_BIT];
    // pins are active low: a falling edge is the event
    wire fall0 = pin0_prev_r & ~pin0_lvl;
    wire fall1 = pin1_prev_r & ~pin1_lvl;

    // ********************************************************************
    // apb decode
    // ********************************************************************
    wire setup_ph = psel & ~penable;
    wire access_ph = psel & penable;
    wire hit_ben = paddr == mih_pkg::OFF_BASIC_EN;
    wire hit_eea = paddr == mih_pkg::OFF_EXT_EN_A;
    wire hit_eeb = paddr == mih_pkg::OFF_EXT_EN_B;
    wire hit_bpr = paddr == mih_pkg::OFF_BASIC_PRI;
    wire hit_epa = paddr == mih_pkg::OFF_EXT_PRI_A;
    wire hit_epb = paddr == mih_pkg::OFF_EXT_PRI_B;
    wire hit_tcr = paddr == mih_pkg::OFF_TIMER_CTL;
    wire hit_pnd = paddr == mih_pkg::OFF_PENDING;
    wire hit_sts = paddr == mih_pkg::OFF_STATUS;
    wire mapped = hit_ben | hit_eea | hit_eeb | hit_bpr | hit_epa
                  | hit_epb | hit_tcr | hit_pnd | hit_sts;
    // the status word is read-only; a write there is refused too
    wire bad_acc = ~mapped | (hit_sts & pwrite);
    wire wr_ok = access_ph & pwrite & ~bad_acc;

    assign pready = access_ph;
    assign pslverr = access_ph & bad_acc;

    // ********************************************************************
    // enable and priority vectors
    // ********************************************************************
    wire global_irq_enable = basic_irq_enable_reg[mih_pkg::GIE_BIT];
    // while the enable is being cleared, only a single-cycle follower
    // still lets the pending request through
    wire gie_eff = global_irq_enable
                   & ~(ea_clear_exec & ~next_single);
    // slot order: basic bits 0-5, ext-a bits 0-7, ext-b bits 0-6
    wire [NSRC-1:0] src_en = {ext_irq_enable_reg_b[6:0],
                              ext_irq_enable_reg_a,
                              basic_irq_enable_reg[5:0]};
    wire [NSRC-1:0] src_hi = {ext_priority_reg_b[6:0],
                              ext_priority_reg_a,
                              basic_priority_reg[5:0]};

    assign arb.pend = pend_r;
    assign arb.en = src_en & {NSRC{gie_eff}} & ~mih_pkg::RSVD_MASK;
    assign arb.hi = src_hi;
    assign arb.hi_busy = hi_busy_r;
    assign arb.lo_busy = lo_busy_r;

    mih_arbiter #(.N(NSRC), .IW(5)) u_arb (
        .a(arb)
    );

    // ********************************************************************
    // pending flags
    // ********************************************************************
    wire [NSRC-1:0] one_hot_cur = NSRC'(1) << cur_idx_r;
    wire call_end = (state_r == mih_pkg::ST_CALL)
                    & (call_cnt_r == 3'(CALL_CYCLES - 1));
    // external flags self-clear only in edge mode
    wire [NSRC-1:0] hw_clr_mask = mih_pkg::HW_CLR_MASK
        & ~({{(NSRC-1){1'b0}}, ~ext0_edge_select} << mih_pkg::SRC_EXT0)
        & ~({{(NSRC-1){1'b0}}, ~ext1_edge_select} << mih_pkg::SRC_EXT1);
    wire [NSRC-1:0] hw_clr = call_end ? (one_hot_cur & hw_clr_mask)
                             : '0;
    wire [NSRC-1:0] hw_set = (src_event
        & ~(NSRC'(1) << mih_pkg::SRC_EXT0)
        & ~(NSRC'(1) << mih_pkg::SRC_EXT1))
        | (NSRC'(ext0_edge_select & fall0) << mih_pkg::SRC_EXT0)
        | (NSRC'(ext1_edge_select & fall1) << mih_pkg::SRC_EXT1);

    // software writes through the pending word or the timer control word
    wire tcr_wr = wr_ok & hit_tcr;
    wire pnd_wr = wr_ok & hit_pnd;
    wire [NSRC-1:0] tcr_mask = (NSRC'(1) << mih_pkg::SRC_EXT0)
        | (NSRC'(1) << mih_pkg::SRC_T0) | (NSRC'(1) << mih_pkg::SRC_EXT1)
        | (NSRC'(1) << mih_pkg::SRC_T1);
    wire [NSRC-1:0] tcr_data =
        (NSRC'(pwdata[mih_pkg::EXT0_FLAG_BIT]) << mih_pkg::SRC_EXT0)
        | (NSRC'(pwdata[mih_pkg::T0_FLAG_BIT]) << mih_pkg::SRC_T0)
        | (NSRC'(pwdata[mih_pkg::EXT1_FLAG_BIT]) << mih_pkg::SRC_EXT1)
        | (NSRC'(pwdata[mih_pkg::T1_FLAG_BIT]) << mih_pkg::SRC_T1);
    wire [NSRC-1:0] sw_mask = pnd_wr ? {NSRC{1'b1}}
                              : (tcr_wr ? tcr_mask : '0);
    wire [NSRC-1:0] sw_data = pnd_wr ? pwdata[NSRC-1:0] : tcr_data;
    wire [NSRC-1:0] after_sw = (pend_r & ~sw_mask) | (sw_data & sw_mask);

    always_comb begin
        // an event set in the same cycle as any clear survives; a software set loses to the call-end clear
        pend_nxt = hw_set | (after_sw & ~hw_clr);
        // level mode: flag is the pin, not a latch
        if (!ext0_edge_select) begin
            pend_nxt[mih_pkg::SRC_EXT0] = ~pin0_lvl;
        end
        if (!ext1_edge_select) begin
            pend_nxt[mih_pkg::SRC_EXT1] = ~pin1_lvl;
        end
        pend_nxt = pend_nxt & ~mih_pkg::RSVD_MASK;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pend_r <= mih_pkg::PEND_RST;
        end else begin
            pend_r <= pend_nxt;
        end
    end

    // ********************************************************************
    // configuration registers
    // ********************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            basic_irq_enable_reg <= mih_pkg::REG8_RST;
            ext_irq_enable_reg_a <= mih_pkg::REG8_RST;
            ext_irq_enable_reg_b <= mih_pkg::REG8_RST;
            basic_priority_reg <= mih_pkg::REG8_RST;
            ext_priority_reg_a <= mih_pkg::REG8_RST;
            ext_priority_reg_b <= mih_pkg::REG8_RST;
            timer_ctl_store_r <= mih_pkg::REG8_RST;
        end else begin
            if (wr_ok && hit_ben) begin
                basic_irq_enable_reg <= pwdata[7:0];
            end else if (ea_clear_exec) begin
                // the core's own clear lands here; isr then reads zero
                basic_irq_enable_reg[mih_pkg::GIE_BIT] <= 1'b0;
            end
            if (wr_ok && hit_eea) begin
                ext_irq_enable_reg_a <= pwdata[7:0];
            end
            if (wr_ok && hit_eeb) begin
                ext_irq_enable_reg_b <= pwdata[7:0];
            end
            if (wr_ok && hit_bpr) begin
                basic_priority_reg <= pwdata[7:0];
            end
            if (wr_ok && hit_epa) begin
                ext_priority_reg_a <= pwdata[7:0];
            end
            if (wr_ok && hit_epb) begin
                ext_priority_reg_b <= pwdata[7:0];
            end
            if (tcr_wr) begin
                timer_ctl_store_r <= pwdata[7:0];
            end
        end
    end

    // ********************************************************************
    // call sequencing
    // ********************************************************************
    // one instruction must finish after a return before re-entry
    wire take = (state_r == mih_pkg::ST_IDLE) & arb.valid
                & instr_boundary & ~skip_one_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= mih_pkg::ST_IDLE;
            call_cnt_r <= 3'h0;
            cur_idx_r <= 5'h00;
            cur_hi_r <= 1'b0;
            call_vector <= 16'h0000;
        end else begin
            case (state_r)
                mih_pkg::ST_IDLE: begin
                    if (take) begin
                        state_r <= mih_pkg::ST_CALL;
                        call_cnt_r <= 3'h0;
                        cur_idx_r <= arb.idx;
                        cur_hi_r <= arb.win_hi;
                        call_vector <= mih_pkg::VEC_BASE
                            + 16'(arb.idx) * mih_pkg::VEC_STEP;
                    end
                end
                mih_pkg::ST_CALL: begin
                    call_cnt_r <= call_cnt_r + 3'h1;
                    if (call_end) begin
                        state_r <= mih_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_r <= mih_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // nesting depth tracks which level is being serviced
    always_ff @(posedge clk) begin
        if (rst) begin
            hi_busy_r <= 1'b0;
            lo_busy_r <= 1'b0;
            skip_one_r <= 1'b0;
        end else begin
            if (call_end) begin
                if (cur_hi_r) begin
                    hi_busy_r <= 1'b1;
                end else begin
                    lo_busy_r <= 1'b1;
                end
            end else if (return_from_interrupt_done) begin
                // return pops the innermost level back to the caller
                if (hi_busy_r) begin
                    hi_busy_r <= 1'b0;
                end else begin
                    lo_busy_r <= 1'b0;
                end
            end
            if (return_from_interrupt_done) begin
                skip_one_r <= 1'b1;
            end else if (instr_boundary) begin
                skip_one_r <= 1'b0;
            end
        end
    end

    assign irq_req = arb.valid;
    assign call_start = take;
    assign call_active = state_r == mih_pkg::ST_CALL;
    assign in_service = {hi_busy_r, lo_busy_r};

    // ********************************************************************
    // read back
    // ********************************************************************
    wire [7:0] timer_ctl_view = {pend_r[mih_pkg::SRC_T1],
        timer_ctl_store_r[6], pend_r[mih_pkg::SRC_T0],
        timer_ctl_store_r[4], pend_r[mih_pkg::SRC_EXT1],
        timer_ctl_store_r[2], pend_r[mih_pkg::SRC_EXT0],
        timer_ctl_store_r[0]};
    wire [31:0] status_view = {20'h00000, call_active, cur_hi_r,
        hi_busy_r, lo_busy_r, skip_one_r, arb.valid, 1'b0, cur_idx_r};
    wire [31:0] rd_mux =
        hit_ben ? {24'h000000, basic_irq_enable_reg} :
        hit_eea ? {24'h000000, ext_irq_enable_reg_a} :
        hit_eeb ? {24'h000000, ext_irq_enable_reg_b} :
        hit_bpr ? {24'h000000, basic_priority_reg} :
        hit_epa ? {24'h000000, ext_priority_reg_a} :
        hit_epb ? {24'h000000, ext_priority_reg_b} :
        hit_tcr ? {24'h000000, timer_ctl_view} :
        hit_pnd ? {11'h000, pend_r} :
        hit_sts ? status_view : 32'h00000000;

    // captured in setup so the word is stable through the access phase
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h00000000;
        end else if (setup_ph && !pwrite) begin
            prdata <= rd_mux;
        end
    end
endmodule // mih_handler

/* File: bench/mih_handler_assertions.sv */
// assertion checker for the interrupt handler call sequencing
`timescale 1ns/1ps
module mih_handler_chk (
    input wire logic clk, // system clock
    input wire logic rst, // sync reset
    input wire logic ea_clear_exec, // enable clear runs
    input wire logic next_single, // short follower
    input wire logic irq_req, // request pending
    input wire logic call_start, // call taken
    input wire logic call_active, // call running
    input wire logic [15:0] call_vector, // call target
    input wire logic [1:0] in_service // busy levels
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_call;
        call_active [*4] ##1 !call_active;
    endsequence
    property p_call; call_start |=> s_call; endproperty
    property p_busy; call_active |-> !call_start; endproperty
    property p_req; call_start |-> irq_req; endproperty
    property p_vec; call_active |-> call_vector[2:0] == 3'h3; endproperty
    property p_hold;
        call_active && $past(call_active) |-> $stable(call_vector);
    endproperty
    property p_svc; $fell(call_active) |-> in_service != 2'h0; endproperty
    property p_hi; in_service[1] |-> !call_start; endproperty
    property p_ea; ea_clear_exec && !next_single |-> !call_start; endproperty
    a_call: assert property (p_call) else $error("call length");
    a_busy: assert property (p_busy) else $error("take in call");
    a_req: assert property (p_req) else $error("take no req");
    a_vec: assert property (p_vec) else $error("vector slot");
    a_hold: assert property (p_hold) else $error("vector moved");
    a_svc: assert property (p_svc) else $error("no busy");
    a_hi: assert property (p_hi) else $error("high preempted");
    a_ea: assert property (p_ea) else $error("taken after clear");
endmodule // mih_handler_chk
bind mih_handler mih_handler_chk u_chk (.clk, .rst, .ea_clear_exec,
    .next_single, .irq_req, .call_start, .call_active, .call_vector,
    .in_service);

/* File: bench/mih_core_model.sv */
// core-side partner: instruction boundaries, enable clears, returns
`timescale 1ns/1ps
module mih_core_model (
    input wire logic clk, // system clock
    input wire logic rst, // sync reset
    input wire logic call_active, // call owns the core
    input wire logic slow, // multi-cycle instructions
    input wire logic clr_cmd, // run an enable clear
    input wire logic ret_cmd, // run a return
    input wire logic short_next, // follower is one cycle
    output logic instr_boundary, // instruction completes
    output logic ea_clear_exec, // enable clear executes
    output logic next_single, // follower is one cycle
    output logic return_from_interrupt_done // return completed
);
    logic [1:0] cnt_r;
    always_ff @(posedge clk) begin
        cnt_r <= rst ? 2'h0 : cnt_r + 2'h1;
    end
    // no boundary while the call sequence runs
    assign instr_boundary = !call_active && (!slow || cnt_r == 2'h3);
    assign ea_clear_exec = clr_cmd;
    // software follows a clear with a long opcode unless told otherwise
    assign next_single = short_next;
    assign return_from_interrupt_done = ret_cmd;
endmodule // mih_core_model

/* File: bench/tb_mih_handler.sv */
// self-checking bench for the interrupt handler
`timescale 1ns/1ps
module tb_mih_handler;
    typedef struct {int slot; logic [15:0] vec; logic hc; logic sl;} mih_row_s;
    logic clk, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic pready, pslverr, err, ib, eac, ns, rdn, irq, cs, ca;
    logic pin0 = 1'b1, pin1 = 1'b1, slow = 1'b0, sn = 1'b0;
    logic [1:0] cmd = 2'h0;
    logic [1:0] isv;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd, e;
    logic [20:0] ev = 21'h0, m;
    logic [15:0] cv;
    int fail_count = 0, samples_checked = 0, n;
    mih_row_s rows [7] = '{'{1, 16'h000B, 1'b1, 1'b0},
        '{3, 16'h001B, 1'b1, 1'b1}, '{4, 16'h0023, 1'b0, 1'b0},
        '{10, 16'h0053, 1'b0, 1'b1}, '{11, 16'h005B, 1'b0, 1'b0},
        '{12, 16'h0063, 1'b0, 1'b1}, '{20, 16'h00A3, 1'b0, 1'b0}};
    mih_handler dut (.clk, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .ext_irq_pin_0(pin0),
        .ext_irq_pin_1(pin1), .src_event(ev), .instr_boundary(ib),
        .ea_clear_exec(eac), .next_single(ns), .return_from_interrupt_done(rdn),
        .irq_req(irq), .call_start(cs), .call_active(ca),
        .call_vector(cv), .in_service(isv));
    mih_core_model core (.clk, .rst, .call_active(ca), .slow, .short_next(sn),
        .clr_cmd(cmd[0]), .ret_cmd(cmd[1]), .instr_boundary(ib),
        .ea_clear_exec(eac), .next_single(ns), .return_from_interrupt_done(rdn));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, logic [11:0] a, logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(rd, x);
    endtask
    task automatic cmdp(input logic [1:0] c);
        @(posedge clk);
        cmd <= c;
        @(posedge clk);
        cmd <= 2'h0;
    endtask
    // slot 20 event pulses one cycle before an enable clear, so its flag is pending while the clear runs
    task automatic clrev(input logic s);
        @(posedge clk);
        ev <= 21'h100000;
        sn <= s;
        @(posedge clk);
        ev <= 21'h0;
        cmd <= 2'h1;
        @(negedge clk);
        chk({31'h0, cs}, {31'h0, s});
        @(posedge clk);
        cmd <= 2'h0;
        sn <= 1'b0;
    endtask
    // waits bounded for a take, then checks the target
    task automatic wcall(input logic [15:0] v);
        n = 0;
        do @(negedge clk) n++; while (cs !== 1'b1 && n < 200);
        chk({31'h0, cs}, 32'h1);
        @(negedge clk);
        chk({16'h0, cv}, {16'h0, v});
        repeat (5) @(negedge clk);
    endtask
    task automatic conclude();
        $display("checked=%0d failed=%0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        conclude();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rdchk(mih_pkg::OFF_BASIC_PRI, 32'h0);
        apb(1'b0, 12'h040, 32'h0);
        chk({31'h0, err}, 32'h1);
        foreach (rows[i]) begin
            m = 21'h1 << rows[i].slot;
            slow <= rows[i].sl;
            apb(1'b1, mih_pkg::OFF_EXT_EN_A, {24'h0, m[13:6]});
            apb(1'b1, mih_pkg::OFF_EXT_EN_B, {25'h0, m[20:14]});
            apb(1'b1, mih_pkg::OFF_BASIC_EN, {24'h0, 2'h2, m[5:0]});
            @(posedge clk);
            ev <= m;
            @(posedge clk);
            ev <= 21'h0;
            wcall(rows[i].vec);
            e = rows[i].hc ? 32'h0 : {11'h0, m};
            rdchk(mih_pkg::OFF_PENDING, e);
            apb(1'b1, mih_pkg::OFF_PENDING, 32'h0);
            cmdp(2'h2);
        end
        slow <= 1'b0;
        clrev(1'b1);
        @(negedge clk);
        chk({16'h0, cv}, 32'h000000A3);
        rdchk(mih_pkg::OFF_BASIC_EN, 32'h0);
        apb(1'b1, mih_pkg::OFF_PENDING, 32'h0);
        cmdp(2'h2);
        apb(1'b1, mih_pkg::OFF_BASIC_EN, 32'h80);
        clrev(1'b0);
        rdchk(mih_pkg::OFF_BASIC_EN, 32'h0);
        apb(1'b1, mih_pkg::OFF_BASIC_EN, 32'h10);
        apb(1'b1, mih_pkg::OFF_PENDING, 32'h10);
        repeat (10) @(negedge clk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, mih_pkg::OFF_BASIC_EN, 32'h80);
        repeat (4) @(negedge clk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, mih_pkg::OFF_BASIC_PRI, 32'h10);
        apb(1'b1, mih_pkg::OFF_BASIC_EN, 32'h90);
        wcall(16'h0023);
        chk({30'h0, isv}, 32'h2);
        cmdp(2'h2);
        wcall(16'h0023);
        apb(1'b1, mih_pkg::OFF_BASIC_PRI, 32'h0);
        apb(1'b1, mih_pkg::OFF_PENDING, 32'h0);
        cmdp(2'h2);
        apb(1'b1, mih_pkg::OFF_BASIC_EN, 32'h0);
        apb(1'b1, mih_pkg::OFF_PENDING, 32'h30);
        apb(1'b1, mih_pkg::OFF_BASIC_EN, 32'hB0);
        wcall(16'h0023);
        apb(1'b1, mih_pkg::OFF_PENDING, 32'h0);
        cmdp(2'h2);
        apb(1'b1, mih_pkg::OFF_BASIC_EN, 32'h0);
        pin0 <= 1'b0;
        repeat (8) @(posedge clk);
        rdchk(mih_pkg::OFF_TIMER_CTL, 32'h2);
        pin0 <= 1'b1;
        repeat (8) @(posedge clk);
        rdchk(mih_pkg::OFF_TIMER_CTL, 32'h0);
        apb(1'b1, mih_pkg::OFF_TIMER_CTL, 32'h1);
        apb(1'b1, mih_pkg::OFF_BASIC_EN, 32'h81);
        pin0 <= 1'b0;
        wcall(16'h0003);
        rdchk(mih_pkg::OFF_TIMER_CTL, 32'h1);
        pin0 <= 1'b1;
        cmdp(2'h2);
        @(negedge clk);
        chk({30'h0, isv}, 32'h0);
        conclude();
    end
endmodule // tb_mih_handler
